// >>> bench/lstc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lstc_params.svh"
module lstc_top_tb;
	import lstc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic        fire_ext, fire_get, ilim_trip, ext_trig_n, bus_get;
	logic        load_active, list_running;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] vin_level, reg_level;
	lstc_rmode_t reg_mode;
	int          fail_count, n_tests, cyc;
	int          ts[10] = '{2, 2, 2, 2, 1, 1, 1, 0, 0, 0};
	int          tk[10] = '{0, 1, 2, 3, 0, 2, 3, 1, 2, 0};
	logic        te[10] = '{1, 1, 1, 0, 0, 1, 0, 0, 0, 1};

	lstc_top lstc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ext_trig_n, .bus_get, .vin_level, .ilim_trip, .load_active, .reg_mode,
		.reg_level, .list_running);
	lstc_trig_src lstc_trig_src_inst (.pclk, .presetn, .fire_ext, .fire_get, .ext_trig_n, .bus_get);

	// ************************************************
	// shared tasks
	// ************************************************
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// idle cycle after release keeps psel from being assigned twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task fire(input int k);
		if (k < 2) begin
			fire_ext <= (k == 0);
			fire_get <= (k == 1);
			@(posedge pclk);
			fire_ext <= 1'b0;
			fire_get <= 1'b0;
			@(posedge pclk);
		end else begin
			apb(1'b1, `LSTC_A_CMD, (k == 2) ? 32'h0000_0002 : 32'h0000_0004);
		end
	endtask

	task arm_imm;
		apb(1'b1, `LSTC_A_CMD, 32'h0000_0001);
		apb(1'b1, `LSTC_A_CMD, 32'h0000_0004);
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task t_src;
		apb(1'b1, `LSTC_A_PEND, 32'h0000_0055);
		apb(1'b1, `LSTC_A_PEND + 8'h04, 32'h0000_0066);
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0108);
		fire(3);
		repeat (4) @(posedge pclk);
		chk({16'h0, reg_level}, 32'h0);
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, `LSTC_A_CTRL, 32'h0000_0100 | (ts[i] << 2));
			apb(1'b1, `LSTC_A_CMD, 32'h0000_0001);
			fire(tk[i]);
			repeat (4) @(posedge pclk);
			apb(1'b0, `LSTC_A_STAT, 32'h0);
			chk({31'h0, rd[0]}, {31'h0, te[i]});
		end
		chk({16'h0, reg_level}, 32'h0000_0055);
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0148);
		repeat (3) @(posedge pclk);
		chk({16'h0, reg_level}, 32'h0000_0066);
		$display("trigger sources done");
	endtask

	task t_tran;
		apb(1'b1, `LSTC_A_TLVL, 32'h00AA_0055);
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0129);
		for (int i = 0; i < 2; i++) begin
			arm_imm();
			repeat (4) @(posedge pclk);
			chk({16'h0, reg_level}, i ? 32'h0000_0055 : 32'h0000_00AA);
		end
		apb(1'b1, `LSTC_A_TTIM, 32'h0);
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0119);
		arm_imm();
		apb(1'b0, `LSTC_A_STAT, 32'h0);
		chk({31'h0, rd[4]}, 32'h1);
		arm_imm();
		apb(1'b0, `LSTC_A_STAT, 32'h0);
		chk({31'h0, rd[0]}, 32'h1);
		repeat (700) @(posedge pclk);
		apb(1'b0, `LSTC_A_STAT, 32'h0);
		chk({31'h0, rd[4]}, 32'h0);
		vin_level <= 16'h00FF;
		apb(1'b1, `LSTC_A_VST, 32'h0000_0100);
		repeat (3) @(posedge pclk);
		chk({31'h0, load_active}, 32'h0);
		vin_level <= 16'h0100;
		repeat (3) @(posedge pclk);
		chk({31'h0, load_active}, 32'h1);
		vin_level <= 16'h0000;
		apb(1'b1, `LSTC_A_VST, 32'h0);
		repeat (3) @(posedge pclk);
		chk({31'h0, load_active}, 32'h1);
		$display("transient and gate done");
	endtask

	task t_list;
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0108);
		apb(1'b1, `LSTC_A_SADR, 32'h0000_0001);
		apb(1'b1, `LSTC_A_SDAT, 32'h0002_0099);
		apb(1'b1, `LSTC_A_SDUR, 32'h0000_0001);
		apb(1'b1, `LSTC_A_LCFG, 32'h0000_0001);
		apb(1'b1, `LSTC_A_SADR, 32'h0);
		apb(1'b1, `LSTC_A_SDAT, 32'h0001_0077);
		apb(1'b1, `LSTC_A_SDUR, 32'h0000_0001);
		apb(1'b1, `LSTC_A_LCFG, 32'h0011_0301);
		apb(1'b1, `LSTC_A_LSEL, 32'h0);
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_010A);
		arm_imm();
		repeat (6) @(posedge pclk);
		chk({31'h0, list_running}, 32'h1);
		chk({30'h0, reg_mode}, {30'h0, constant_current_mode});
		chk({16'h0, reg_level}, 32'h0000_0077);
		repeat (450) @(posedge pclk);
		chk({31'h0, list_running}, 32'h1);
		// three runs of list 0 take about 606 cycles, then list 1 about 202
		repeat (240) @(posedge pclk);
		chk({16'h0, reg_level}, 32'h0000_0099);
		repeat (200) @(posedge pclk);
		chk({31'h0, list_running}, 32'h0);
		arm_imm();
		ilim_trip <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({31'h0, list_running}, 32'h0);
		ilim_trip <= 1'b0;
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_000A);
		apb(1'b0, `LSTC_A_TLVL, 32'h0);
		chk(rd, 32'h00AA_0055);
		apb(1'b1, `LSTC_A_CMD, 32'h0000_0308);
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0004);
		apb(1'b1, `LSTC_A_CMD, 32'h0000_0310);
		apb(1'b0, `LSTC_A_CTRL, 32'h0);
		chk({30'h0, rd[3:2]}, 32'h2);
		apb(1'b0, 8'h2C, 32'h0);
		chk({31'h0, slv}, 32'h1);
		apb(1'b1, `LSTC_A_SADR, 32'h0000_3109);
		apb(1'b1, `LSTC_A_SDAT, 32'h0000_1234);
		apb(1'b0, `LSTC_A_SDAT, 32'h0);
		chk(rd, 32'h0000_1234);
		apb(1'b1, `LSTC_A_SADR, 32'h0000_3209);
		apb(1'b0, `LSTC_A_SDAT, 32'h0);
		chk(rd, 32'h0);
		$display("list and storage done");
	endtask

	task t_ctrl;
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0300);
		apb(1'b1, `LSTC_A_CTRL, 32'h0000_0301);
		apb(1'b0, `LSTC_A_CTRL, 32'h0);
		chk({30'h0, rd[9:8]}, 32'h2);
		apb(1'b1, `LSTC_A_CMD, 32'h0000_0008);
		// slot 0 now holds the bus source, reset default is external
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `LSTC_A_CTRL, 32'h0);
		chk({30'h0, rd[3:2]}, 32'h0);
		$display("local control and power-up recall done");
	endtask

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc > 10000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, fire_ext, fire_get, ilim_trip} = 7'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		vin_level = 16'h0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_src();
		t_tran();
		t_list();
		t_ctrl();
		close_out();
	end
endmodule
`default_nettype wire

// >>> bench/lstc_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
// far side: bus trigger pulses and external trigger line
module lstc_trig_src (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// requests from the bench
	input  wire logic fire_ext,
	input  wire logic fire_get,
	// trigger lines
	output logic      ext_trig_n,
	output logic      bus_get
);
	// line idles high as a pulled-up ttl input, low one cycle per request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_trig_n <= 1'b1;
			bus_get    <= 1'b0;
		end else begin
			ext_trig_n <= ~fire_ext;
			bus_get    <= fire_get;
		end
	end
endmodule
`default_nettype wire

// >>> src/lstc_dwell_timer.sv
`timescale 1ns/1ps
`default_nettype none

// counts len ticks of PER cycles, then pulses done
module lstc_dwell_timer #(
	parameter int W   = 34,
	parameter int PER = 200
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic [W-1:0] len,
	// result
	output logic              done
);
	logic [W-1:0] cnt_reg;
	logic [15:0]  sub_reg;
	logic         busy_reg;
	logic         done_reg;

	wire tick = busy_reg & (sub_reg == 16'(PER - 1));
	wire last = tick & (cnt_reg <= W'(1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= '0;
			sub_reg  <= 16'h0000;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (start) begin
			// zero length still gives the shortest step
			cnt_reg  <= (len == '0) ? W'(1) : len;
			sub_reg  <= 16'h0000;
			busy_reg <= 1'b1;
			done_reg <= 1'b0;
		end else if (stop) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= last;
			if (last)
				busy_reg <= 1'b0;
			sub_reg <= (tick | ~busy_reg) ? 16'h0000 : sub_reg + 16'h0001;
			if (tick)
				cnt_reg <= cnt_reg - W'(1);
		end
	end

	assign done = done_reg;

endmodule

`default_nettype wire

// >>> src/lstc_params.svh
`ifndef LSTC_PARAMS_SVH
`define LSTC_PARAMS_SVH

// ************************************************
// timing
// ************************************************
`define LSTC_CLK_NS      50
`define LSTC_STEP_MIN_US 10
`define LSTC_STEP_MAX_S  99999
`define LSTC_TICK_CYC    ((`LSTC_STEP_MIN_US * 1000) / `LSTC_CLK_NS)
`define LSTC_DUR_W       34

// ************************************************
// storage sizes
// ************************************************
`define LSTC_LISTS 10
`define LSTC_STEPS 50
`define LSTC_SLOTS 10
`define LSTC_MEM_D 500

// ************************************************
// register offsets
// ************************************************
`define LSTC_A_CTRL  8'h00
`define LSTC_A_CMD   8'h04
`define LSTC_A_LSEL  8'h08
`define LSTC_A_STAT  8'h0C
`define LSTC_A_SADR  8'h10
`define LSTC_A_SDAT  8'h14
`define LSTC_A_SDUR  8'h18
`define LSTC_A_LCFG  8'h1C
`define LSTC_A_VST   8'h20
`define LSTC_A_TLVL  8'h24
`define LSTC_A_TTIM  8'h28
`define LSTC_A_PEND  8'h30

// ************************************************
// field positions
// ************************************************
`define LSTC_C_ON    8
`define LSTC_C_LOCAL 9
`define LSTC_K_ARM   0
`define LSTC_K_TRG   1
`define LSTC_K_IMM   2
`define LSTC_K_SAV   3
`define LSTC_K_RCL   4

// ************************************************
// reset values
// ************************************************
`define LSTC_VST_RST 16'h0000
`define LSTC_CTL_RST 32'h0000_0004

`endif

// >>> src/lstc_pkg.sv
package lstc_pkg;

	typedef enum logic [1:0] {
		lstc_op_basic = 2'h0,
		lstc_op_tran  = 2'h1,
		lstc_op_list  = 2'h2
	} lstc_op_t;

	typedef enum logic [1:0] {
		lstc_src_bus  = 2'h0,
		lstc_src_ext  = 2'h1,
		lstc_src_hold = 2'h2
	} lstc_src_t;

	typedef enum logic [1:0] {
		lstc_tr_cont   = 2'h0,
		lstc_tr_pulse  = 2'h1,
		lstc_tr_toggle = 2'h2
	} lstc_tran_t;

	typedef enum logic [1:0] {
		constant_voltage_mode    = 2'h0,
		constant_current_mode    = 2'h1,
		constant_resistance_mode = 2'h2,
		constant_power_mode      = 2'h3
	} lstc_rmode_t;

	typedef enum logic [2:0] {
		lst_idle = 3'b001,
		lst_load = 3'b010,
		lst_run  = 3'b100
	} lstc_lst_t;

	typedef enum logic [3:0] {
		pst_idle = 4'b0001,
		pst_rise = 4'b0010,
		pst_high = 4'b0100,
		pst_fall = 4'b1000
	} lstc_pst_t;

	typedef struct packed {
		lstc_rmode_t      mode;
		logic [3:0][15:0] pend;
		logic [15:0]      tlo;
		logic [15:0]      thi;
		lstc_src_t        src;
		logic [15:0]      vst;
	} lstc_set_t;

endpackage

// >>> src/lstc_top.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lstc_params.svh"

// Function
// - step dwell from 10 us to 99999 s
// - ten lists of up to fifty steps
// - each step has mode, setpoint, duration
// - list repeats until repeat count used
// - finished list starts its chained successor
// - input shutdown aborts a running list
// - trigger copies pending presets to immediate
// - pulsed trigger gives exactly one pulse
// - toggled trigger swaps low and high level
// - list trigger starts the selected list
// - bus, external, hold sources; remote only (triggers are not gated by local_reg)
// - bus source takes GET or TRG
// - external source fires on falling edge
// - hold ignores external edges and TRG
// - immediate trigger works with every source
// - triggers ignored unless armed by initiate
// - input on/off keeps all settings
// - local mode change forces input off
// - start-voltage gate, zero disables it
// - ten parameter sets saved and recalled
// - power-up recalls parameter set zero
// - triggers discarded while pulse runs
module lstc_top (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// trigger and sense inputs
	input  wire logic                ext_trig_n,
	input  wire logic                bus_get,
	input  wire logic [15:0]         vin_level,
	input  wire logic                ilim_trip,
	// regulation demand
	output logic                     load_active,
	output lstc_pkg::lstc_rmode_t    reg_mode,
	output logic [15:0]              reg_level,
	output logic                     list_running
);
	import lstc_pkg::*;

	// ************************************************
	// state
	// ************************************************
	lstc_op_t         op_reg;
	lstc_src_t        src_reg;
	lstc_tran_t       tran_reg;
	lstc_rmode_t      bmode_reg;
	lstc_lst_t        lst_reg;
	lstc_pst_t        pst_reg;
	lstc_rmode_t      mode_reg;
	logic             on_reg, local_reg, armed_reg, ext_prev_reg;
	logic             thigh_reg, boot_reg, act_reg, ready_reg, err_reg, run_reg;
	logic [15:0]      vst_reg, tlo_reg, thi_reg, lvl_reg;
	logic [29:0]      ttim_reg;
	logic [31:0]      rdata_reg;
	logic [3:0]       lsel_reg, ed_list_reg, run_list_reg;
	logic [5:0]       ed_step_reg, run_step_reg;
	logic [7:0]       rep_left_reg;
	logic [3:0][15:0] pend_reg, imm_reg;
	logic [15:0]      st_sp  [`LSTC_MEM_D];
	lstc_rmode_t      st_mode[`LSTC_MEM_D];
	logic [33:0]      st_dur [`LSTC_MEM_D];
	logic [5:0]       lc_cnt [`LSTC_LISTS];
	logic [7:0]       lc_rep [`LSTC_LISTS];
	logic [3:0]       lc_chn [`LSTC_LISTS];
	logic             lc_cen [`LSTC_LISTS];
	lstc_set_t        slot_mem[`LSTC_SLOTS];
	logic             slot_ok [`LSTC_SLOTS];

	// ************************************************
	// apb decode
	// ************************************************
	wire        setup  = psel & ~penable;
	wire        wr     = psel & penable & pwrite & ready_reg & ~err_reg;
	wire        w_ctrl = wr & (paddr == `LSTC_A_CTRL);
	wire        w_cmd  = wr & (paddr == `LSTC_A_CMD);
	wire        w_lsel = wr & (paddr == `LSTC_A_LSEL);
	wire        w_sadr = wr & (paddr == `LSTC_A_SADR);
	wire        w_sdat = wr & (paddr == `LSTC_A_SDAT);
	wire        w_sdur = wr & (paddr == `LSTC_A_SDUR);
	wire        w_lcfg = wr & (paddr == `LSTC_A_LCFG);
	wire        w_vst  = wr & (paddr == `LSTC_A_VST);
	wire        w_tlvl = wr & (paddr == `LSTC_A_TLVL);
	wire        w_ttim = wr & (paddr == `LSTC_A_TTIM);
	wire        w_pend = wr & (paddr[7:4] == 4'(`LSTC_A_PEND >> 4)) & (paddr[1:0] == 2'h0);
	wire        hit    = (paddr <= `LSTC_A_TTIM || paddr[7:4] == 4'h3) && paddr[1:0] == 2'h0;
	wire [3:0]  slot   = pwdata[11:8];
	wire        slot_v = slot < 4'(`LSTC_SLOTS);
	wire        c_arm  = w_cmd & pwdata[`LSTC_K_ARM];
	wire        c_trg  = w_cmd & pwdata[`LSTC_K_TRG];
	wire        c_imm  = w_cmd & pwdata[`LSTC_K_IMM];
	wire        c_sav  = w_cmd & pwdata[`LSTC_K_SAV] & slot_v;
	wire        c_rcl  = w_cmd & pwdata[`LSTC_K_RCL] & slot_v;
	wire [8:0]  ed_idx = 9'(ed_list_reg) * 9'(`LSTC_STEPS) + 9'(ed_step_reg);
	wire [8:0]  rn_idx = 9'(run_list_reg) * 9'(`LSTC_STEPS) + 9'(run_step_reg);
	wire        ed_ok  = ed_list_reg < 4'(`LSTC_LISTS) && ed_step_reg < 6'(`LSTC_STEPS);

	// ************************************************
	// save and recall
	// ************************************************
	wire        rc_boot = boot_reg & slot_ok[0];
	wire        do_rc   = rc_boot | (c_rcl & slot_ok[slot]);
	lstc_set_t  rc_set;
	lstc_set_t  cur_set;
	assign rc_set  = slot_mem[boot_reg ? 4'h0 : slot];
	assign cur_set = '{bmode_reg, pend_reg, tlo_reg, thi_reg, src_reg, vst_reg};

	// slots are the nonvolatile store, so reset leaves them alone
	always_ff @(posedge pclk) begin
		if (c_sav) begin
			slot_mem[slot] <= cur_set;
			slot_ok[slot]  <= 1'b1;
		end
	end

	// ************************************************
	// trigger qualification
	// ************************************************
	wire ext_fall = ext_prev_reg & ~ext_trig_n;
	wire trig_hit = c_imm
	              | (src_reg == lstc_src_bus & (c_trg | bus_get))
	              | (src_reg == lstc_src_ext & ext_fall);
	wire is_pulse = op_reg == lstc_op_tran & tran_reg == lstc_tr_pulse;
	wire p_block  = is_pulse & pst_reg != pst_idle;
	wire accept   = armed_reg & trig_hit & ~p_block;
	wire act_next = on_reg & ~ilim_trip & (vst_reg == 16'h0000 | vin_level >= vst_reg);
	wire running  = lst_reg != lst_idle;
	wire l_abort  = running & act_reg & ~act_next;
	// a trigger during a running list is used up but restarts nothing
	wire l_go     = accept & op_reg == lstc_op_list & ~running & lc_cnt[lsel_reg] != 6'h00;

	// ************************************************
	// configuration registers
	// ************************************************
	lstc_op_t new_op;
	assign new_op = lstc_op_t'(pwdata[1:0]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_reg    <= lstc_op_basic;
			src_reg   <= lstc_src_ext;
			tran_reg  <= lstc_tr_cont;
			bmode_reg <= constant_voltage_mode;
			on_reg    <= 1'b0;
			local_reg <= 1'b0;
			vst_reg   <= `LSTC_VST_RST;
			tlo_reg   <= 16'h0000;
			thi_reg   <= 16'h0000;
			pend_reg  <= '0;
			ttim_reg  <= 30'h0000_0000;
		end else if (do_rc) begin
			bmode_reg <= rc_set.mode;
			pend_reg  <= rc_set.pend;
			tlo_reg   <= rc_set.tlo;
			thi_reg   <= rc_set.thi;
			src_reg   <= rc_set.src;
			vst_reg   <= rc_set.vst;
		end else begin
			if (w_ctrl) begin
				op_reg    <= new_op;
				src_reg   <= lstc_src_t'(pwdata[3:2]);
				tran_reg  <= lstc_tran_t'(pwdata[5:4]);
				bmode_reg <= lstc_rmode_t'(pwdata[7:6]);
				local_reg <= pwdata[`LSTC_C_LOCAL];
				// forced off wins over a write that turns it on
				on_reg    <= pwdata[`LSTC_C_ON] & ~(local_reg & new_op != op_reg);
			end else if (ilim_trip)
				on_reg <= 1'b0;
			if (w_vst)
				vst_reg <= pwdata[15:0];
			if (w_tlvl) begin
				tlo_reg <= pwdata[15:0];
				thi_reg <= pwdata[31:16];
			end
			if (w_ttim)
				ttim_reg <= pwdata[29:0];
			if (w_pend)
				pend_reg[paddr[3:2]] <= pwdata[15:0];
		end
	end

	// ************************************************
	// list storage
	// ************************************************
	always_ff @(posedge pclk) begin
		if (w_sdat & ed_ok) begin
			st_sp[ed_idx]         <= pwdata[15:0];
			st_mode[ed_idx]       <= lstc_rmode_t'(pwdata[17:16]);
			st_dur[ed_idx][33:32] <= pwdata[19:18];
		end
		if (w_sdur & ed_ok)
			st_dur[ed_idx][31:0] <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ed_list_reg <= 4'h0;
			ed_step_reg <= 6'h00;
			lsel_reg    <= 4'h0;
			for (int i = 0; i < `LSTC_LISTS; i++) begin
				lc_cnt[i] <= 6'h00;
				lc_rep[i] <= 8'h00;
				lc_chn[i] <= 4'h0;
				lc_cen[i] <= 1'b0;
			end
		end else begin
			if (w_sadr) begin
				ed_list_reg <= pwdata[3:0];
				ed_step_reg <= pwdata[13:8];
			end
			if (w_lsel & pwdata[3:0] < 4'(`LSTC_LISTS))
				lsel_reg <= pwdata[3:0];
			if (w_lcfg & ed_list_reg < 4'(`LSTC_LISTS)) begin
				// counts above the list size are clipped
				lc_cnt[ed_list_reg] <= (pwdata[5:0] > 6'(`LSTC_STEPS)) ? 6'(`LSTC_STEPS) : pwdata[5:0];
				lc_rep[ed_list_reg] <= pwdata[15:8];
				lc_chn[ed_list_reg] <= (pwdata[19:16] < 4'(`LSTC_LISTS)) ? pwdata[19:16] : 4'h0;
				lc_cen[ed_list_reg] <= pwdata[20];
			end
		end
	end

	// ************************************************
	// trigger actions
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_reg    <= 1'b0;
			ext_prev_reg <= 1'b1;
			thigh_reg    <= 1'b0;
			imm_reg      <= '0;
			boot_reg     <= 1'b1;
		end else begin
			boot_reg     <= 1'b0;
			ext_prev_reg <= ext_trig_n;
			// a new initiate in the same cycle keeps the device armed
			armed_reg    <= c_arm | (armed_reg & ~accept);
			if (accept & op_reg == lstc_op_basic)
				imm_reg <= pend_reg;
			if (accept & op_reg == lstc_op_tran & tran_reg == lstc_tr_toggle)
				thigh_reg <= ~thigh_reg;
		end
	end

	// ************************************************
	// pulse sequencer
	// ************************************************
	wire        p_go = accept & is_pulse;
	wire        p_done;
	wire        p_start = p_go | (p_done & (pst_reg == pst_rise | pst_reg == pst_high));
	logic [9:0] p_len;
	assign p_len = (pst_reg == pst_idle) ? ttim_reg[9:0] :
	               (pst_reg == pst_rise) ? ttim_reg[19:10] : ttim_reg[29:20];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pst_reg <= pst_idle;
		else begin
			unique case (pst_reg)
				pst_idle: if (p_go) pst_reg <= pst_rise;
				pst_rise: if (p_done) pst_reg <= pst_high;
				pst_high: if (p_done) pst_reg <= pst_fall;
				pst_fall: if (p_done) pst_reg <= pst_idle;
				default:  pst_reg <= pst_idle;
			endcase
		end
	end

	lstc_dwell_timer #(.W(10), .PER(`LSTC_TICK_CYC)) u_pulse_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (p_start),
		.stop    (1'b0),
		.len     (p_len),
		.done    (p_done)
	);

	// ************************************************
	// list sequencer
	// ************************************************
	wire s_done;
	wire s_start = lst_reg == lst_load;
	wire s_last  = 6'(run_step_reg + 6'h01) >= lc_cnt[run_list_reg];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lst_reg      <= lst_idle;
			run_list_reg <= 4'h0;
			run_step_reg <= 6'h00;
			rep_left_reg <= 8'h00;
		end else if (l_abort)
			lst_reg <= lst_idle;
		else begin
			unique case (lst_reg)
				lst_idle: if (l_go) begin
					lst_reg      <= lst_load;
					run_list_reg <= lsel_reg;
					run_step_reg <= 6'h00;
					rep_left_reg <= (lc_rep[lsel_reg] == 8'h00) ? 8'h00 : lc_rep[lsel_reg] - 8'h01;
				end
				lst_load: lst_reg <= lst_run;
				lst_run: if (s_done) begin
					lst_reg <= lst_load;
					if (!s_last)
						run_step_reg <= run_step_reg + 6'h01;
					else if (rep_left_reg != 8'h00) begin
						run_step_reg <= 6'h00;
						rep_left_reg <= rep_left_reg - 8'h01;
					end else if (lc_cen[run_list_reg] & lc_cnt[lc_chn[run_list_reg]] != 6'h00) begin
						run_list_reg <= lc_chn[run_list_reg];
						run_step_reg <= 6'h00;
						rep_left_reg <= (lc_rep[lc_chn[run_list_reg]] == 8'h00) ? 8'h00
						              : lc_rep[lc_chn[run_list_reg]] - 8'h01;
					end else
						lst_reg <= lst_idle;
				end
				default: lst_reg <= lst_idle;
			endcase
		end
	end

	lstc_dwell_timer #(.W(`LSTC_DUR_W), .PER(`LSTC_TICK_CYC)) u_step_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (s_start),
		.stop    (l_abort),
		.len     (st_dur[rn_idx]),
		.done    (s_done)
	);

	// ************************************************
	// regulation demand and apb answer
	// ************************************************
	lstc_rmode_t mode_next;
	logic [15:0] lvl_next;
	logic [31:0] rd_next;

	always_comb begin
		mode_next = bmode_reg;
		lvl_next  = imm_reg[bmode_reg];
		if (op_reg == lstc_op_tran)
			lvl_next = (pst_reg != pst_idle | (tran_reg == lstc_tr_toggle & thigh_reg)) ? thi_reg : tlo_reg;
		if (running) begin
			mode_next = st_mode[rn_idx];
			lvl_next  = st_sp[rn_idx];
		end
		if (!act_next)
			lvl_next = 16'h0000;
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		unique case (paddr)
			`LSTC_A_CTRL: rd_next = {22'h0, local_reg, on_reg, bmode_reg, tran_reg, src_reg, op_reg};
			`LSTC_A_LSEL: rd_next = {28'h0, lsel_reg};
			`LSTC_A_STAT: rd_next = {10'h0, run_step_reg, 4'h0, run_list_reg, 3'h0,
			                         pst_reg != pst_idle, thigh_reg, act_reg, running, armed_reg};
			`LSTC_A_SADR: rd_next = {18'h0, ed_step_reg, 4'h0, ed_list_reg};
			`LSTC_A_SDAT: rd_next = ed_ok ? {12'h0, st_dur[ed_idx][33:32], st_mode[ed_idx], st_sp[ed_idx]} : 32'h0;
			`LSTC_A_SDUR: rd_next = ed_ok ? st_dur[ed_idx][31:0] : 32'h0;
			`LSTC_A_LCFG: rd_next = ed_list_reg < 4'(`LSTC_LISTS) ? {11'h0, lc_cen[ed_list_reg],
			                         lc_chn[ed_list_reg], lc_rep[ed_list_reg], 2'h0, lc_cnt[ed_list_reg]} : 32'h0;
			`LSTC_A_VST:  rd_next = {16'h0, vst_reg};
			`LSTC_A_TLVL: rd_next = {thi_reg, tlo_reg};
			`LSTC_A_TTIM: rd_next = {2'h0, ttim_reg};
			default:      rd_next = (paddr[7:4] == 4'h3) ? {16'h0, pend_reg[paddr[3:2]]} : 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_reg   <= 1'b0;
			mode_reg  <= constant_voltage_mode;
			lvl_reg   <= 16'h0000;
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			run_reg   <= 1'b0;
		end else begin
			run_reg   <= running;
			act_reg   <= act_next;
			mode_reg  <= mode_next;
			lvl_reg   <= lvl_next;
			ready_reg <= setup;
			err_reg   <= setup & ~hit;
			rdata_reg <= (setup & ~pwrite & hit) ? rd_next : 32'h0000_0000;
		end
	end

	assign prdata       = rdata_reg;
	assign pready       = ready_reg;
	assign pslverr      = err_reg;
	assign load_active  = act_reg;
	assign reg_mode     = mode_reg;
	assign reg_level    = lvl_reg;
	assign list_running = run_reg;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_arm_gate:    assert property ($rose(pst_reg == pst_rise) |-> $past(armed_reg))
		else $error("pulse started while not armed");
	chk_pulse_busy:  assert property ((pst_reg == pst_high && trig_hit) |=> pst_reg != pst_rise)
		else $error("trigger restarted a running pulse");
	chk_toggle_flip: assert property ((accept && op_reg == lstc_op_tran && tran_reg == lstc_tr_toggle)
		|=> thigh_reg != $past(thigh_reg))
		else $error("toggle trigger did not swap level");
	chk_hold_src:    assert property ((src_reg == lstc_src_hold && !c_imm) |-> !accept)
		else $error("hold source accepted a non-immediate trigger");
	chk_ext_edge:    assert property ((accept && src_reg == lstc_src_ext && !c_imm)
		|-> ($past(ext_trig_n) && !ext_trig_n))
		else $error("external trigger without falling edge");
	chk_preset_copy: assert property ((accept && op_reg == lstc_op_basic) |=> imm_reg == $past(pend_reg))
		else $error("preset levels not copied");
	chk_list_start:  assert property (l_go |=> lst_reg == lst_load ##1 lst_reg == lst_run)
		else $error("list did not start");
	chk_list_abort:  assert property (l_abort |=> lst_reg == lst_idle)
		else $error("list kept running after shutdown");
	chk_local_off:   assert property ((w_ctrl && local_reg && new_op != op_reg && !do_rc) |=> !on_reg)
		else $error("mode change under local control left input on");
	chk_gate_off:    assert property ((vst_reg != 16'h0000 && vin_level < vst_reg) |=> !act_reg)
		else $error("load active below start voltage");

	cov_pulse:  cover property (pst_reg == pst_rise ##[1:1000] pst_reg == pst_fall ##[1:1000] pst_reg == pst_idle);
	cov_repeat: cover property (lst_reg == lst_run && s_done && s_last && rep_left_reg != 8'h00);
	cov_chain:  cover property (lst_reg == lst_run && s_done && s_last && lc_cen[run_list_reg]);
	cov_recall: cover property (c_rcl && slot_ok[slot]);

endmodule

`default_nettype wire
